// file: hdl/rssc_pkg.sv
// Purpose: Shared constants for the remote status and system control block.
// Assumes: 32-bit AXI4-Lite register access, one 100 MHz clock.
// Notes:   Register offsets are byte addresses, one aligned word each.
`default_nettype none
package rssc_pkg;
   // ==========================================================================
   // Register map
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_BUS_ADDR = 8'h04;
   localparam logic [7:0] OFS_PON_SLOT = 8'h08;
   localparam logic [7:0] OFS_COMMAND  = 8'h0C;
   localparam logic [7:0] OFS_ERR_NEXT = 8'h10;
   localparam logic [7:0] OFS_VERSION  = 8'h14;
   localparam logic [7:0] OFS_STATE    = 8'h18;
   localparam logic [7:0] OFS_STAT_0   = 8'h20;
   localparam int         STAT_REGS    = 6;
   // ==========================================================================
   // Control fields
   localparam int CTRL_SLOPE_BIT = 0;
   localparam int CTRL_MODE_LSB  = 1;
   localparam int CTRL_SRC_LSB   = 3;
   localparam int CTRL_SEC_BIT   = 5;
   localparam int CMD_PRESET_BIT = 0;
   localparam int CMD_TRG_BIT    = 1;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   // ==========================================================================
   // Values
   localparam logic [4:0]  BUS_ADDR_OFF   = 5'h1F;
   localparam logic [4:0]  BUS_ADDR_RESET = 5'h0F;
   localparam logic [6:0]  SLOT_MAX       = 7'h63;
   localparam logic [6:0]  SLOT_PREVIOUS  = 7'h63;
   localparam logic [15:0] PTR_PRESET     = 16'h7FFF;
   localparam logic [15:0] NTR_PRESET     = 16'h0000;
   localparam logic [15:0] ENABLE_PRESET  = 16'h0000;
   localparam logic [31:0] VERSION_X10    = 32'h00004DD0;
   localparam logic [15:0] ERR_NONE       = 16'h0000;
   localparam int          ERR_DEPTH      = 8;
   // ==========================================================================
   // Interface messages
   localparam logic [7:0] MSG_GET = 8'h08;
   localparam logic [7:0] MSG_DCL = 8'h14;
   localparam logic [7:0] MSG_SDC = 8'h04;
   localparam logic [7:0] MSG_LLO = 8'h11;
   // ==========================================================================
   // Modes
   typedef enum logic [1:0] {MODE_CONT, MODE_TRIG, MODE_GATE, MODE_BURST} rssc_mode_e;
   typedef enum logic [1:0] {SRC_MAN, SRC_BUS, SRC_INT, SRC_EXT} rssc_src_e;
endpackage : rssc_pkg
`default_nettype wire

// file: hdl/rssc_core.sv
// Purpose: Remote status, system settings and bus message handling.
// Assumes: All inputs synchronous to sys_clk; one AXI4-Lite access per direction.
// Notes:   The settings store and trigger logic sit outside; this block pulses them.
//
// Behaviour
// (R1) Trigger input edge selectable rising or falling, readable
// (R2) Trigger source applies only in triggered modes
// (R3) Preset clears both status enable masks
// (R4) Preset loads positive filters with 32767
// (R5) Preset loads negative filters with zero
// (R6) Status conditions never set by device
// (R7) Error read returns oldest entry, then removes
// (R8) Bus address 0 to 31, readable
// (R9) Address 31 takes device off bus
// (R10) Version query returns 1992.0
// (R11) Security on to off wipes settings
// (R12) Power-on slot 0 to 99 restored
// (R13) Slot 99 restores state before power-down
// (R14) Group trigger fires only in bus-triggered modes
// (R15) Group trigger equals common trigger command
// (R16) Device clear empties input and output buffers
// (R17) Device clear resets message processing
// (R18) Selected clear acts only when listen-addressed
// (R19) Lockout needs listen address and remote enable
// (R20) Empty queue reads zero; queries answer in order
`default_nettype none
module rssc_core
   import rssc_pkg::*;
(
   // Clock and reset
   input  wire  logic        sys_clk,
   input  wire  logic        sys_rst,
   // AXI4-Lite slave
   input  wire  logic [31:0] s_axi_awaddr,
   input  wire  logic        s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire  logic [31:0] s_axi_wdata,
   input  wire  logic [3:0]  s_axi_wstrb,
   input  wire  logic        s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire  logic        s_axi_bready,
   input  wire  logic [31:0] s_axi_araddr,
   input  wire  logic        s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire  logic        s_axi_rready,
   // Interface messages from the bus controller
   input  wire  logic        msg_valid,
   input  wire  logic [7:0]  msg_code,
   input  wire  logic        listen_addressed,
   input  wire  logic        remote_enable,
   // Trigger inputs
   input  wire  logic        ext_trig_in,
   input  wire  logic        man_key,
   input  wire  logic        int_tick,
   // Front panel and settings store
   input  wire  logic        fp_addr_valid,
   input  wire  logic [4:0]  fp_addr,
   input  wire  logic [6:0]  nv_slot_in,
   input  wire  logic        err_push,
   input  wire  logic [15:0] err_code,
   // Outputs to the instrument
   output logic              trig_fire,
   output logic              clr_in_buf,
   output logic              clr_out_queue,
   output logic              msg_proc_reset,
   output logic              remote_lockout,
   output logic              front_panel_enable,
   output logic              off_bus,
   output logic              wipe_settings,
   output logic              restore_stb,
   output logic [6:0]        restore_slot,
   output logic              restore_previous
);
   import rssc_pkg::*;

   // ==========================================================================
   // Bus slave
   logic        aw_have_q, w_have_q, bvalid_q, rvalid_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [31:0] rdata_q, rd_data_d;
   logic        rd_hit_d, wr_hit_d;
   logic        wr_go, rd_go;
   logic [7:0]  rd_addr;

   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready  = !w_have_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign wr_go   = aw_have_q && w_have_q && !bvalid_q;
   assign rd_go   = s_axi_arvalid && !rvalid_q;
   assign rd_addr = s_axi_araddr[7:0];

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h00000000;
         w_strb_q  <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_have_q) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr[7:0];
         end else if (wr_go) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_have_q) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_have_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= 2'h0;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit_d ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Writes with partial strobes only touch lanes that carry a field.
   logic        wr_lane0, wr_lane1;
   logic        wr_ctrl, wr_addr, wr_slot, wr_cmd;
   assign wr_lane0 = wr_go && w_strb_q[0];
   assign wr_lane1 = wr_go && w_strb_q[1];
   assign wr_ctrl  = wr_lane0 && (aw_addr_q == OFS_CTRL);
   assign wr_addr  = wr_lane0 && (aw_addr_q == OFS_BUS_ADDR);
   assign wr_slot  = wr_lane0 && (aw_addr_q == OFS_PON_SLOT);
   assign wr_cmd   = wr_lane0 && (aw_addr_q == OFS_COMMAND);

   always_comb begin
      wr_hit_d = (aw_addr_q == OFS_CTRL) || (aw_addr_q == OFS_BUS_ADDR) ||
                 (aw_addr_q == OFS_PON_SLOT) || (aw_addr_q == OFS_COMMAND) ||
                 (aw_addr_q >= OFS_STAT_0 && aw_addr_q < OFS_STAT_0 + 8'(4 * STAT_REGS) &&
                  aw_addr_q[1:0] == 2'h0);
   end

   // ==========================================================================
   // Settings registers
   logic [5:0]  ctrl_q;
   logic [4:0]  bus_addr_q;
   logic [6:0]  pon_slot_q;
   logic        boot_q, wipe_q;
   rssc_mode_e  mode;
   rssc_src_e   src;
   logic        sec_fall;

   assign mode     = rssc_mode_e'(ctrl_q[CTRL_MODE_LSB +: 2]);
   assign src      = rssc_src_e'(ctrl_q[CTRL_SRC_LSB +: 2]);
   assign sec_fall = wr_ctrl && ctrl_q[CTRL_SEC_BIT] && !w_data_q[CTRL_SEC_BIT];

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RESET;
         wipe_q <= 1'b0;
      end else begin
         wipe_q <= sec_fall;                                    // R11
         if (sec_fall) begin
            ctrl_q <= CTRL_RESET;                               // R11
         end else if (wr_ctrl) begin
            ctrl_q <= w_data_q[5:0];                            // R1
         end
      end
   end

   // A front-panel change is the only way back from the off-bus address.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_addr_q <= BUS_ADDR_RESET;
      end else if (fp_addr_valid && !remote_lockout) begin
         bus_addr_q <= fp_addr;                                 // R9
      end else if (wr_addr && !off_bus) begin
         bus_addr_q <= (w_data_q[31:5] != 27'h0) ? BUS_ADDR_OFF : w_data_q[4:0]; // R8
      end
   end

   // The slot is caught from the settings store on the first edge after reset.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         boot_q           <= 1'b1;
         pon_slot_q       <= 7'h00;
         restore_stb      <= 1'b0;
         restore_slot     <= 7'h00;
         restore_previous <= 1'b0;
      end else begin
         boot_q      <= 1'b0;
         restore_stb <= boot_q;                                 // R12
         if (boot_q) begin
            pon_slot_q       <= (nv_slot_in > SLOT_MAX) ? SLOT_MAX : nv_slot_in;
            restore_slot     <= (nv_slot_in > SLOT_MAX) ? SLOT_MAX : nv_slot_in;
            restore_previous <= (nv_slot_in >= SLOT_PREVIOUS);  // R13
         end else if (sec_fall) begin
            pon_slot_q <= 7'h00;                                // R11
         end else if (wr_slot) begin
            pon_slot_q <= (w_data_q[31:7] != 25'h0 || w_data_q[6:0] > SLOT_MAX) ?
                          SLOT_MAX : w_data_q[6:0];             // R12
         end
      end
   end

   assign wipe_settings = wipe_q;

   // ==========================================================================
   // Status structures: enables and filters only, conditions stay zero.
   logic [15:0] stat_q [STAT_REGS];                             // R6
   logic        preset;
   assign preset = wr_cmd && w_data_q[CMD_PRESET_BIT];

   for (genvar i = 0; i < STAT_REGS; i++) begin : g_stat
      localparam logic [15:0] PRESET_VAL = (i % 3 == 1) ? PTR_PRESET :
                                           (i % 3 == 2) ? NTR_PRESET : ENABLE_PRESET;
      logic hit;
      assign hit = wr_go && (aw_addr_q == OFS_STAT_0 + 8'(4 * i));
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            stat_q[i] <= PRESET_VAL;
         end else if (preset) begin
            stat_q[i] <= PRESET_VAL;                            // R3 R4 R5
         end else if (hit) begin
            if (w_strb_q[0]) begin
               stat_q[i][7:0] <= w_data_q[7:0];
            end
            if (w_strb_q[1]) begin
               stat_q[i][15:8] <= w_data_q[15:8];
            end
         end
      end
   end

   // ==========================================================================
   // Error queue
   logic [15:0] err_mem [ERR_DEPTH];
   logic [2:0]  err_rd_q, err_wr_q;
   logic [3:0]  err_cnt_q;
   logic        err_pop, err_wr;
   assign err_pop = rd_go && rd_addr == OFS_ERR_NEXT && err_cnt_q != 4'h0; // R7
   assign err_wr  = err_push && err_cnt_q != 4'(ERR_DEPTH);

   always_ff @(posedge sys_clk) begin
      if (err_wr) begin
         err_mem[err_wr_q] <= err_code;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         err_rd_q  <= 3'h0;
         err_wr_q  <= 3'h0;
         err_cnt_q <= 4'h0;
      end else begin
         if (err_wr) begin
            err_wr_q <= err_wr_q + 3'h1;
         end
         if (err_pop) begin
            err_rd_q <= err_rd_q + 3'h1;                        // R7
         end
         err_cnt_q <= err_cnt_q + {3'h0, err_wr} - {3'h0, err_pop};
      end
   end

   // ==========================================================================
   // Register read; one read at a time keeps answers in command order.
   always_comb begin
      rd_data_d = 32'h00000000;
      rd_hit_d  = 1'b1;
      unique case (rd_addr)
         OFS_CTRL:     rd_data_d = {26'h0, ctrl_q};
         OFS_BUS_ADDR: rd_data_d = {27'h0, bus_addr_q};        // R8
         OFS_PON_SLOT: rd_data_d = {25'h0, pon_slot_q};
         OFS_COMMAND:  rd_data_d = 32'h00000000;
         OFS_ERR_NEXT: rd_data_d = {16'h0, (err_cnt_q != 4'h0) ? err_mem[err_rd_q] : ERR_NONE}; // R20
         OFS_VERSION:  rd_data_d = VERSION_X10;                 // R10
         OFS_STATE:    rd_data_d = {24'h0, err_cnt_q, 1'b0, off_bus, remote_lockout, 1'b0};
         default: begin
            if (rd_addr >= OFS_STAT_0 && rd_addr < OFS_STAT_0 + 8'(4 * STAT_REGS) &&
                rd_addr[1:0] == 2'h0) begin
               rd_data_d = {16'h0, stat_q[3'(rd_addr[4:2])]};
            end else begin
               rd_hit_d = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= 2'h0;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_data_d;
         rresp_q  <= rd_hit_d ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ==========================================================================
   // Interface messages; all are ignored while off the bus.
   logic msg_get, msg_dcl, msg_sdc, msg_llo, clear_go;
   assign off_bus  = (bus_addr_q == BUS_ADDR_OFF);             // R9
   assign msg_get  = msg_valid && !off_bus && msg_code == MSG_GET;
   assign msg_dcl  = msg_valid && !off_bus && msg_code == MSG_DCL;
   assign msg_sdc  = msg_valid && !off_bus && msg_code == MSG_SDC && listen_addressed; // R18
   assign msg_llo  = msg_valid && !off_bus && msg_code == MSG_LLO && listen_addressed && remote_enable;
   assign clear_go = msg_dcl || msg_sdc;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         clr_in_buf     <= 1'b0;
         clr_out_queue  <= 1'b0;
         msg_proc_reset <= 1'b0;
      end else begin
         clr_in_buf     <= clear_go;                            // R16
         clr_out_queue  <= clear_go;                            // R16
         msg_proc_reset <= clear_go;                            // R17
      end
   end

   // Lockout lasts until the controller drops remote enable.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         remote_lockout <= 1'b0;
      end else if (!remote_enable) begin
         remote_lockout <= 1'b0;
      end else if (msg_llo) begin
         remote_lockout <= 1'b1;                                // R19
      end
   end

   assign front_panel_enable = !remote_lockout;

   // ==========================================================================
   // Trigger
   logic ext_prev_q, man_prev_q, armed, ext_edge, bus_trig, fire_d;
   assign armed    = (mode != MODE_CONT);                       // R2
   assign ext_edge = ctrl_q[CTRL_SLOPE_BIT] ? (ext_prev_q && !ext_trig_in)
                                            : (!ext_prev_q && ext_trig_in); // R1
   assign bus_trig = msg_get || (wr_cmd && w_data_q[CMD_TRG_BIT]); // R15
   assign fire_d   = armed && ((src == SRC_BUS && bus_trig) ||  // R14
                               (src == SRC_EXT && ext_edge) ||
                               (src == SRC_MAN && man_key && !man_prev_q && !remote_lockout) ||
                               (src == SRC_INT && int_tick));

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_prev_q <= 1'b0;
         man_prev_q <= 1'b0;
         trig_fire  <= 1'b0;
      end else begin
         ext_prev_q <= ext_trig_in;
         man_prev_q <= man_key;
         trig_fire  <= fire_d;
      end
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   chk_preset_enable: assert property (preset |=> stat_q[0] == 16'h0000 && stat_q[3] == 16'h0000) // R3
      else $error("preset left an enable mask set");
   chk_preset_ptr: assert property (preset |=> stat_q[1] == 16'h7FFF && stat_q[4] == 16'h7FFF) // R4
      else $error("preset positive filter wrong");
   chk_preset_ntr: assert property (preset |=> stat_q[2] == 16'h0000 && stat_q[5] == 16'h0000) // R5
      else $error("preset negative filter wrong");
   chk_fire_mode: assert property (trig_fire |-> $past(mode) != MODE_CONT) // R2
      else $error("trigger fired in continuous mode");
   chk_get_fire: assert property (msg_get && armed && src == SRC_BUS |=> trig_fire) // R14
      else $error("group trigger did not fire");
   chk_cmd_trigger: assert property (wr_cmd && w_data_q[1] && armed && src == SRC_BUS |=> trig_fire) // R15
      else $error("trigger command did not fire");
   chk_slope_fire: assert property (armed && src == SRC_EXT && ctrl_q[0] && $fell(ext_trig_in) |=> trig_fire) // R1
      else $error("falling slope trigger missed");
   chk_dcl_clear: assert property (msg_dcl |=> clr_in_buf && clr_out_queue && msg_proc_reset) // R16
      else $error("device clear not acted on");
   chk_sdc_unaddressed: assert property (msg_valid && msg_code == 8'h04 && !listen_addressed
                                         && !(msg_code == 8'h14) |=> !clr_in_buf) // R18
      else $error("selected clear acted while not listening");
   chk_offbus_mute: assert property (off_bus && msg_valid |=> !clr_in_buf && !msg_proc_reset) // R9
      else $error("message taken while off the bus");
   chk_llo_enter: assert property (msg_llo |=> remote_lockout && !front_panel_enable) // R19
      else $error("local lockout not entered");
   chk_version_read: assert property (rd_go && rd_addr == 8'h14 |=> s_axi_rdata == 32'h00004DD0) // R10
      else $error("version read wrong");
   chk_err_empty: assert property (rd_go && rd_addr == 8'h10 && err_cnt_q == 4'h0 |=> s_axi_rdata == 32'h0) // R20
      else $error("empty error queue read not zero");
   chk_err_pop: assert property (err_pop && !err_push |=> err_cnt_q == $past(err_cnt_q) - 4'h1) // R7
      else $error("error read did not remove entry");
   chk_sec_wipe: assert property (sec_fall |=> wipe_settings && ctrl_q == 6'h00) // R11
      else $error("security off did not wipe");
   chk_slot_range: assert property (pon_slot_q <= 7'h63) // R12
      else $error("power-on slot out of range");
   chk_restore_prev: assert property (restore_stb && restore_slot == 7'h63 |-> restore_previous) // R13
      else $error("slot 99 did not select previous state");

   cov_bus_trigger: cover property (msg_get ##1 trig_fire);
   cov_sdc_clear:   cover property (msg_sdc ##1 clr_in_buf);
   cov_lockout:     cover property (msg_llo ##1 remote_lockout ##[1:20] !remote_lockout);
   cov_err_pop:     cover property (err_pop ##1 s_axi_rvalid);
endmodule : rssc_core
`default_nettype wire

// file: verif/rssc_ctl_model.sv
// Purpose: Bus controller model that sends interface messages.
// Assumes: A message lasts one clock; listen and remote levels are held.
// Notes:   The idle code is the inverse of the last one, so it never looks valid.
`default_nettype none
module rssc_ctl_model (
   // Clock
   input  wire logic       sys_clk,
   // Messages
   output var  logic       msg_valid,
   output var  logic [7:0] msg_code,
   output var  logic       listen_addressed,
   output var  logic       remote_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      msg_valid = 1'b0;
      msg_code = 8'hFF;
      listen_addressed = 1'b0;
      remote_enable = 1'b0;
   end
   // ==========================================================================
   // Send one message
   task automatic send(input logic [7:0] code, input logic la, input logic ren);
      @(posedge sys_clk);
      msg_valid <= 1'b1;
      msg_code <= code;
      listen_addressed <= la;
      remote_enable <= ren;
      @(posedge sys_clk);
      msg_valid <= 1'b0;
      msg_code <= ~code;
   endtask : send
endmodule : rssc_ctl_model
`default_nettype wire

// file: verif/rssc_core_tb.sv
// Purpose: Self-checking bench for the remote status and control block.
// Assumes: Partner model drives the message inputs.
// Notes:   Manual and internal trigger pins stay idle; only bus and external triggers fire.
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module rssc_core_tb;
   import rssc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, msg_valid;
   logic        listen_addressed, remote_enable, ext_trig_in, man_key, int_tick, fp_addr_valid, err_push;
   logic        trig_fire, clr_in_buf, clr_out_queue, msg_proc_reset, remote_lockout, front_panel_enable;
   logic        off_bus, wipe_settings, restore_stb, restore_previous, prev_seen;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_d, seed;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
   logic [3:0]  s_axi_wstrb;
   logic [7:0]  msg_code, n_trg, n_clr, n_wipe, e;
   logic [4:0]  fp_addr;
   logic [6:0]  nv_slot_in, restore_slot, slot_seen;
   logic [15:0] err_code;
   int          n_fail, checks_done, cyc, q[$];
   rssc_core rssc_core_inst (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .msg_valid,
      .msg_code, .listen_addressed, .remote_enable, .ext_trig_in, .man_key, .int_tick, .fp_addr_valid, .fp_addr,
      .nv_slot_in, .err_push, .err_code, .trig_fire, .clr_in_buf, .clr_out_queue, .msg_proc_reset,
      .remote_lockout, .front_panel_enable, .off_bus, .wipe_settings, .restore_stb, .restore_slot,
      .restore_previous);
   rssc_ctl_model rssc_ctl_model_inst (.sys_clk, .msg_valid, .msg_code, .listen_addressed, .remote_enable);
   // ==========================================================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   task automatic give_verdict;
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] x);
      @(posedge sys_clk);
      s_axi_araddr <= {24'h0, a};
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      `CHK(rd_d, x)
   endtask : rc
   task automatic msg(input logic [7:0] c, input logic la, input logic ren);
      rssc_ctl_model_inst.send(c, la, ren);
      repeat (2) @(posedge sys_clk);
   endtask : msg
   // ==========================================================================
   // Clock, pulse counters and hang limit
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      n_trg <= n_trg + 8'(trig_fire === 1'b1);
      n_clr <= n_clr + 8'({clr_in_buf, clr_out_queue, msg_proc_reset} === 3'h7);
      n_wipe <= n_wipe + 8'(wipe_settings === 1'b1);
      if (restore_stb) slot_seen <= restore_slot;
      if (restore_stb) prev_seen <= restore_previous;
      if (cyc > 20000) begin
         n_fail++;
         give_verdict();
      end
   end
   // ==========================================================================
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {ext_trig_in, man_key, int_tick, fp_addr_valid, err_push, cyc, n_trg, n_clr, n_wipe} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, err_code, fp_addr} = '0;
      s_axi_wstrb = 4'hF;
      nv_slot_in = SLOT_PREVIOUS;
      seed = 32'h2D79C3C9;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      `CHK({prev_seen, slot_seen}, {1'b1, SLOT_PREVIOUS})
      rc(OFS_VERSION, VERSION_X10);
      rc(OFS_ERR_NEXT, 32'(ERR_NONE));
      rc(8'h40, 32'h0);
      `CHK(rd_r, 2'h2)
      for (int i = 0; i < STAT_REGS; i++) begin
         seed = xs(seed);
         wr(OFS_STAT_0 + 8'(4 * i), seed);
      end
      wr(OFS_COMMAND, 32'h1);
      for (int i = 0; i < STAT_REGS; i++) rc(OFS_STAT_0 + 8'(4 * i), (i % 3 == 1) ? 32'h7FFF : 32'h0);
      for (int i = 0; i < 3; i++) begin
         seed = xs(seed);
         @(posedge sys_clk);
         {err_push, err_code} <= {1'b1, seed[15:0]};
         q.push_back(seed[15:0]);
      end
      @(posedge sys_clk);
      err_push <= 1'b0;
      while (q.size() > 0) rc(OFS_ERR_NEXT, 32'(q.pop_front()));
      rc(OFS_ERR_NEXT, 32'(ERR_NONE));
      for (int m = 0; m < 4; m++) for (int s = 0; s < 4; s++) begin
         wr(OFS_CTRL, 32'((m << CTRL_MODE_LSB) | (s << CTRL_SRC_LSB)));
         e = n_trg + ((m != 0 && s == 1) ? 8'h02 : 8'h00);
         msg(MSG_GET, 1'b1, 1'b0);
         wr(OFS_COMMAND, 32'h2);
         repeat (3) @(posedge sys_clk);
         `CHK(n_trg, e)
      end
      wr(OFS_CTRL, 32'h1);
      rc(OFS_CTRL, 32'h1);
      wr(OFS_CTRL, 32'h1B);
      e = n_trg;
      ext_trig_in <= 1'b1;
      repeat (3) @(posedge sys_clk);
      ext_trig_in <= 1'b0;
      repeat (3) @(posedge sys_clk);
      `CHK(n_trg, e + 8'h01)
      e = n_clr;
      msg(MSG_DCL, 1'b0, 1'b0);
      `CHK(n_clr, e + 8'h01)
      msg(MSG_SDC, 1'b0, 1'b0);
      `CHK(n_clr, e + 8'h01)
      msg(MSG_SDC, 1'b1, 1'b0);
      `CHK(n_clr, e + 8'h02)
      msg(MSG_LLO, 1'b1, 1'b0);
      `CHK(remote_lockout, 1'b0)
      msg(MSG_LLO, 1'b1, 1'b1);
      `CHK({remote_lockout, front_panel_enable}, 2'h2)
      wr(OFS_CTRL, 32'h23);
      wr(OFS_CTRL, 32'h03);
      @(posedge sys_clk);
      `CHK(n_wipe, 8'h01)
      rc(OFS_CTRL, 32'h0);
      wr(OFS_PON_SLOT, 32'h78);
      rc(OFS_PON_SLOT, 32'(SLOT_MAX));
      wr(OFS_BUS_ADDR, 32'h14);
      rc(OFS_BUS_ADDR, 32'h14);
      wr(OFS_BUS_ADDR, 32'(BUS_ADDR_OFF));
      rc(OFS_BUS_ADDR, 32'(BUS_ADDR_OFF));
      e = n_clr;
      msg(MSG_DCL, 1'b1, 1'b0);
      `CHK({off_bus, n_clr}, {1'b1, e})
      @(posedge sys_clk);
      {fp_addr_valid, fp_addr} <= {1'b1, 5'h05};
      @(posedge sys_clk);
      fp_addr_valid <= 1'b0;
      rc(OFS_BUS_ADDR, 32'h5);
      give_verdict();
   end
endmodule : rssc_core_tb
`undef CHK
`default_nettype wire
